// >>> design/cool_ctrl.sv
// Cooling-mode compressor protection and indoor fan tap selection
`timescale 1ns/1ps
`include "cool_ctrl_regs.svh"
module cool_ctrl #(
   parameter int SEC_CYCLES = `SEC_CYCLES
) (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire cool_ctrl_pkg::remote_cmd_t cmd,
   input  wire cool_ctrl_pkg::temps_t  temps,
   output logic                        comp_enable,
   output cool_ctrl_pkg::fan_tap_t     fan_tap,
   output logic                        quiet_led,
   output logic                        dew_active
);
   localparam int TW = 13;
   localparam int NT = 9;
   // Timer slots
   localparam int T_DELAY    = 0;
   localparam int T_SAVE     = 1;
   localparam int T_FREEZE   = 2;
   localparam int T_RUN      = 3;
   localparam int T_DELTA    = 4;
   localparam int T_DEW      = 5;
   localparam int T_QBASE    = 6;
   localparam int T_QSTEP    = 7;
   localparam int T_SPARE    = 8;
   localparam logic [TW-1:0] LIMITS [NT] = '{
      TW'(`RESTART_DELAY_MIN * `MIN_SECONDS),
      TW'(`TIME_SAVE_MIN * `MIN_SECONDS),
      TW'(`FREEZE_HOLD_MIN * `MIN_SECONDS),
      TW'(`RUN_MIN_MIN * `MIN_SECONDS),
      TW'(`DELTA_HOLD_MIN * `MIN_SECONDS),
      TW'(`DEW_HOLD_MIN * `MIN_SECONDS),
      TW'(`QUIET_BASE_MIN * `MIN_SECONDS),
      TW'((`QUIET_BASE_MIN + `QUIET_STEP_MIN) * `MIN_SECONDS),
      TW'(1)
   };

   typedef enum logic [1:0] {
      AUTO_HIGH = 2'b01,
      AUTO_MID  = 2'b10
   } auto_state_t;

   logic                   sec_tick;
   cool_ctrl_pkg::temps_t  samp_q;
   logic                   comp_q;
   logic                   power_q;
   logic                   first_q;
   logic                   freeze_lock_q;
   logic                   setpoint_stop_q;
   logic [7:0]             dew_ref_q;
   auto_state_t            auto_q;
   logic [NT-1:0]          cond;
   logic [NT-1:0]          done;
   logic                   power_rise;
   logic                   unit_run;
   logic                   at_setpoint;
   logic                   above_on;
   logic                   delay_ok;
   logic                   freeze_trip;
   logic                   rev_trip;
   logic                   start_ok;
   logic                   stop_now;
   logic                   dew_cond;
   logic                   dew_stable;
   logic                   low_tap_now;
   logic                   quiet_low_run;
   logic [8:0]             intake_w;
   logic [8:0]             exch_w;
   logic [8:0]             ref_w;

   sec_timebase #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_timebase (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .sec_tick (sec_tick)
   );

   // Sensor codes refreshed once per second
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         samp_q <= '0;
      end else if (sec_tick) begin
         samp_q <= temps;
      end
   end

   assign intake_w = {1'b0, samp_q.intake};
   assign exch_w   = {1'b0, samp_q.exchanger};
   assign ref_w    = {1'b0, dew_ref_q};

   assign unit_run    = cmd.power_on && cmd.cool_mode;
   assign power_rise  = cmd.power_on && !power_q;
   assign at_setpoint = samp_q.intake <= samp_q.setpoint;
   assign above_on    = intake_w >= ({1'b0, samp_q.setpoint} + `T_ON_HYST);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         power_q <= 1'b0;
      end else begin
         power_q <= cmd.power_on;
      end
   end

   // Duration conditions; each counter restarts whenever its condition is seen false
   always_comb begin
      cond           = '0;
      cond[T_DELAY]  = !comp_q && !power_rise;
      cond[T_SAVE]   = !comp_q && !power_rise;
      cond[T_FREEZE] = comp_q && (samp_q.exchanger < `T_FREEZE_TRIP);
      cond[T_RUN]    = comp_q;
      cond[T_DELTA]  = comp_q && (intake_w <= exch_w + `T_DELTA_REV);
      cond[T_DEW]    = dew_cond;
      cond[T_QBASE]  = quiet_low_run;
      cond[T_QSTEP]  = quiet_low_run;
      cond[T_SPARE]  = 1'b0;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_timer
         hold_timer #(
            .W (TW)
         ) u_timer (
            .sys_clk  (sys_clk),
            .reset    (reset),
            .sec_tick (sec_tick),
            .cond     (cond[gi]),
            .limit    (LIMITS[gi]),
            .done     (done[gi])
         );
      end
   endgenerate

   // Delay counts as met from reset until the compressor first stops or a power-on edge arrives
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         first_q <= 1'b1;
      end else if (comp_q && stop_now) begin
         first_q <= 1'b0;
      end else if (power_rise) begin
         first_q <= 1'b0;
      end
   end

   assign delay_ok    = first_q || done[T_DELAY];
   assign freeze_trip = done[T_FREEZE];
   assign rev_trip    = done[T_RUN] && done[T_DELTA];

   // Freeze lock: trip wins over recovery in the same cycle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         freeze_lock_q <= 1'b0;
      end else if (freeze_trip) begin
         freeze_lock_q <= 1'b1;
      end else if (samp_q.exchanger >= `T_FREEZE_RECOVER) begin
         freeze_lock_q <= 1'b0;
      end
   end

   assign stop_now = !unit_run || at_setpoint || freeze_trip || rev_trip;
   // Time save restarts inside the band, never below the off threshold
   assign start_ok = unit_run && delay_ok && !freeze_lock_q && !at_setpoint
                     && (above_on || done[T_SAVE]);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         comp_q <= 1'b0;
      end else if (comp_q) begin
         if (stop_now) begin
            comp_q <= 1'b0;
         end
      end else if (start_ok) begin
         comp_q <= 1'b1;
      end
   end

   assign comp_enable = comp_q;

   // Auto fan phase: remembers the first thermostat stop of this run
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         setpoint_stop_q <= 1'b0;
      end else if (power_rise || !unit_run) begin
         setpoint_stop_q <= 1'b0;
      end else if (comp_q && at_setpoint) begin
         setpoint_stop_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         auto_q <= AUTO_HIGH;
      end else begin
         case (auto_q)
            AUTO_HIGH: begin
               if (setpoint_stop_q && comp_q) begin
                  auto_q <= AUTO_MID;
               end
            end
            AUTO_MID: begin
               if (!unit_run) begin
                  auto_q <= AUTO_HIGH;
               end
            end
            default: begin
               auto_q <= AUTO_HIGH;
            end
         endcase
      end
   end

   // Dew prevention: room reference follows intake until the window opens
   assign low_tap_now = cmd.fan_sel == cool_ctrl_pkg::FAN_LOW;
   assign dew_stable  = (intake_w <= ref_w + `T_DEW_BAND)
                        && (ref_w <= intake_w + `T_DEW_BAND);
   assign dew_cond    = dew_stable
                        && samp_q.intake > `T_DEW_INTAKE_LO
                        && samp_q.intake < `T_DEW_INTAKE_HI
                        && samp_q.setpoint < `T_DEW_SET_MAX
                        && comp_q && unit_run && low_tap_now
                        && !cmd.quiet;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dew_ref_q <= 8'h00;
      end else if (!dew_cond) begin
         dew_ref_q <= samp_q.intake;
      end
   end

   // Timer done is gated by the live condition, so cancel is immediate
   assign dew_active = done[T_DEW];

   assign quiet_low_run = unit_run && cmd.quiet && low_tap_now;
   assign quiet_led     = cmd.power_on && cmd.quiet;

   // Tap selection; taps are output from a flip-flop
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         fan_tap <= cool_ctrl_pkg::TAP_STOP;
      end else if (!unit_run) begin
         fan_tap <= cool_ctrl_pkg::TAP_STOP;
      end else if (cmd.quiet) begin
         case (cmd.fan_sel)
            cool_ctrl_pkg::FAN_HIGH: begin
               fan_tap <= cool_ctrl_pkg::TAP_QUIET_TOP;
            end
            cool_ctrl_pkg::FAN_MED: begin
               fan_tap <= cool_ctrl_pkg::TAP_QUIET_MIDDLE;
            end
            cool_ctrl_pkg::FAN_LOW: begin
               if (done[T_QSTEP]) begin
                  fan_tap <= cool_ctrl_pkg::TAP_QUIET_BOT_180;
               end else if (done[T_QBASE]) begin
                  fan_tap <= cool_ctrl_pkg::TAP_QUIET_BOT_100;
               end else begin
                  fan_tap <= cool_ctrl_pkg::TAP_QUIET_BOTTOM;
               end
            end
            default: begin
               fan_tap <= (auto_q == AUTO_MID) ? cool_ctrl_pkg::TAP_QUIET_MIDDLE
                                               : cool_ctrl_pkg::TAP_QUIET_TOP;
            end
         endcase
      end else begin
         case (cmd.fan_sel)
            cool_ctrl_pkg::FAN_HIGH: begin
               fan_tap <= cool_ctrl_pkg::TAP_TOP;
            end
            cool_ctrl_pkg::FAN_MED: begin
               fan_tap <= cool_ctrl_pkg::TAP_MIDDLE;
            end
            cool_ctrl_pkg::FAN_LOW: begin
               fan_tap <= dew_active ? cool_ctrl_pkg::TAP_BOOSTED
                                     : cool_ctrl_pkg::TAP_BOTTOM;
            end
            default: begin
               fan_tap <= (auto_q == AUTO_MID) ? cool_ctrl_pkg::TAP_MIDDLE
                                               : cool_ctrl_pkg::TAP_TOP;
            end
         endcase
      end
   end
endmodule

// >>> design/cool_ctrl_regs.svh
// Constants for the cooling compressor and fan controller
// Overview of operation
// - After a remote off, compressor restarts only 3 minutes after remote on.
// - At setpoint in cooling, stop compressor and hold it off 3 minutes.
// - After 7 minutes off, restart compressor even inside the thermostat band.
// - Exchanger below 2C for 4 minutes stops compressor; fan setting kept.
// - After freeze stop, allow restart at 10C, still with restart delay.
// - Run 5 min plus intake-exchanger difference <=2.5C for 2 min stops compressor.
// - Dew prevention after 30 minutes of all its listed conditions together.
// - Dew prevention cancels at once when any condition fails.
// - Dew prevention with manual low uses the boosted low tap.
// - Auto fan: high until first setpoint stop, medium after restart.
// - Three manual fan settings low, medium, high from the remote.
// - Quiet mode lights the indicator and selects the quiet taps.
// - Quiet low: 1 h base, 30 min plus 100 rpm, then plus 180 rpm.
`ifndef COOL_CTRL_REGS_SVH
`define COOL_CTRL_REGS_SVH

`define SYS_CLK_HZ        50000000
`define SEC_TIME_MS       1000
`define SEC_CYCLES        (`SYS_CLK_HZ / 1000 * `SEC_TIME_MS)

`define RESTART_DELAY_MIN 3
`define TIME_SAVE_MIN     7
`define FREEZE_HOLD_MIN   4
`define RUN_MIN_MIN       5
`define DELTA_HOLD_MIN    2
`define DEW_HOLD_MIN      30
`define QUIET_BASE_MIN    60
`define QUIET_STEP_MIN    30
`define MIN_SECONDS       60

// Temperature codes: half degree per step, zero at 0C
`define T_FREEZE_TRIP     8'h04
`define T_FREEZE_RECOVER  8'h14
`define T_DELTA_REV       9'h005
`define T_DEW_INTAKE_LO   8'h30
`define T_DEW_INTAKE_HI   8'h3c
`define T_DEW_SET_MAX     8'h32
`define T_DEW_BAND        9'h002
`define T_ON_HYST         9'h002

`endif

// >>> design/cool_ctrl_pkg.sv
// Types shared by the cooling controller
package cool_ctrl_pkg;
   typedef enum logic [1:0] {
      FAN_AUTO = 2'h0,
      FAN_LOW  = 2'h1,
      FAN_MED  = 2'h2,
      FAN_HIGH = 2'h3
   } fan_sel_t;

   typedef enum logic [3:0] {
      TAP_STOP          = 4'h0,
      TAP_TOP           = 4'h1,
      TAP_MIDDLE        = 4'h2,
      TAP_BOTTOM        = 4'h3,
      TAP_BOOSTED       = 4'h4,
      TAP_QUIET_TOP     = 4'h5,
      TAP_QUIET_MIDDLE  = 4'h6,
      TAP_QUIET_BOTTOM  = 4'h7,
      TAP_QUIET_BOT_100 = 4'h8,
      TAP_QUIET_BOT_180 = 4'h9
   } fan_tap_t;

   typedef struct packed {
      logic     power_on;
      logic     cool_mode;
      logic     quiet;
      fan_sel_t fan_sel;
   } remote_cmd_t;

   typedef struct packed {
      logic [7:0] intake;
      logic [7:0] setpoint;
      logic [7:0] exchanger;
   } temps_t;
endpackage

// >>> design/sec_timebase.sv
// Fixed prescaler producing a one-cycle tick each second
`timescale 1ns/1ps
`include "cool_ctrl_regs.svh"
module sec_timebase #(
   parameter int SEC_CYCLES = `SEC_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   output logic      sec_tick
);
   logic [31:0] count_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         count_q  <= 32'h0;
         sec_tick <= 1'b0;
      end else if (count_q == 32'(SEC_CYCLES - 1)) begin
         count_q  <= 32'h0;
         sec_tick <= 1'b1;
      end else begin
         count_q  <= count_q + 32'h1;
         sec_tick <= 1'b0;
      end
   end
endmodule

// >>> design/hold_timer.sv
// Seconds counter that runs while its condition holds continuously
`timescale 1ns/1ps
module hold_timer #(
   parameter int W = 13
) (
   input  wire logic         sys_clk,
   input  wire logic         reset,
   input  wire logic         sec_tick,
   input  wire logic         cond,
   input  wire logic [W-1:0] limit,
   output logic              done
);
   logic [W-1:0] count_q;

   always_ff @(posedge sys_clk) begin
      if (reset || !cond) begin
         count_q <= '0;
      end else if (sec_tick && count_q < limit) begin
         count_q <= count_q + W'(1);
      end
   end

   // Qualified by cond so a dropped condition clears at once
   assign done = cond && (count_q >= limit);
endmodule

// >>> dv/cool_ctrl_checker.sv
// Port-level assertions for the cooling controller
`timescale 1ns/1ps
module cool_ctrl_checker #(
   parameter int SEC_CYCLES = 4
) (
   input wire logic                       sys_clk,
   input wire logic                       reset,
   input wire cool_ctrl_pkg::remote_cmd_t cmd,
   input wire cool_ctrl_pkg::temps_t      temps,
   input wire logic                       comp_enable,
   input wire cool_ctrl_pkg::fan_tap_t    fan_tap,
   input wire logic                       quiet_led,
   input wire logic                       dew_active
);
   // Tick phase is hidden at the ports, so one second of slack
   localparam int HOLD_MIN = 179 * SEC_CYCLES;
   localparam int STOP_LAG = SEC_CYCLES + 2;
   localparam int SAT_MAX  = 1000000;
   logic run;
   int   off_cnt_q;
   int   warm_cnt_q;
   assign run = cmd.power_on & cmd.cool_mode;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Reset leaves the delay met; a power-on edge starts it over
   always_ff @(posedge sys_clk) begin
      if (reset) off_cnt_q <= SAT_MAX;
      else if (comp_enable || $rose(cmd.power_on)) off_cnt_q <= 0;
      else if (off_cnt_q < SAT_MAX) off_cnt_q <= off_cnt_q + 1;
   end
   always_ff @(posedge sys_clk) begin
      if (reset || !run || temps.intake > temps.setpoint) warm_cnt_q <= 0;
      else if (warm_cnt_q < SAT_MAX) warm_cnt_q <= warm_cnt_q + 1;
   end
   a_quiet_led_level: assert property (quiet_led == (cmd.power_on & cmd.quiet))
      else $error("quiet indicator wrong");
   a_fan_stop_idle: assert property (!run |=> fan_tap == cool_ctrl_pkg::TAP_STOP)
      else $error("fan not stopped while idle");
   a_manual_top: assert property (run && !cmd.quiet && cmd.fan_sel == cool_ctrl_pkg::FAN_HIGH
      |=> fan_tap == cool_ctrl_pkg::TAP_TOP)
      else $error("manual high tap wrong");
   a_manual_middle: assert property (run && !cmd.quiet && cmd.fan_sel == cool_ctrl_pkg::FAN_MED
      |=> fan_tap == cool_ctrl_pkg::TAP_MIDDLE)
      else $error("manual medium tap wrong");
   a_quiet_top_tap: assert property (run && cmd.quiet && cmd.fan_sel == cool_ctrl_pkg::FAN_HIGH
      |=> fan_tap == cool_ctrl_pkg::TAP_QUIET_TOP)
      else $error("quiet high tap wrong");
   a_dew_boost: assert property (dew_active && cmd.fan_sel == cool_ctrl_pkg::FAN_LOW
      |=> fan_tap == cool_ctrl_pkg::TAP_BOOSTED)
      else $error("dew boost tap missing");
   a_dew_conds: assert property (dew_active |-> run && comp_enable && !cmd.quiet
      && cmd.fan_sel == cool_ctrl_pkg::FAN_LOW)
      else $error("dew active without its conditions");
   a_reset_off: assert property (disable iff (1'b0) reset
      |=> !comp_enable && fan_tap == cool_ctrl_pkg::TAP_STOP)
      else $error("outputs not cleared by reset");
   a_restart_hold: assert property ($rose(comp_enable) |-> off_cnt_q >= HOLD_MIN)
      else $error("compressor restarted too soon");
   a_setpoint_stop: assert property (warm_cnt_q > STOP_LAG |-> !comp_enable)
      else $error("compressor runs at setpoint");
   c_comp_start: cover property ($rose(comp_enable));
   c_comp_stop: cover property ($fell(comp_enable));
   c_dew_on: cover property ($rose(dew_active));
   c_quiet_last: cover property (fan_tap == cool_ctrl_pkg::TAP_QUIET_BOT_180);
endmodule

// >>> dv/room_model.sv
// Sensor front end: room, setpoint and coil readings
`timescale 1ns/1ps
module room_model (
   input  wire logic                  sys_clk,
   input  wire cool_ctrl_pkg::temps_t target,
   output cool_ctrl_pkg::temps_t      temps
);
   // Readings settle a clock after the room changes
   always_ff @(posedge sys_clk) begin
      temps <= target;
   end
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the cooling controller
`timescale 1ns/1ps
module testbench;
   localparam int SEC = 4;
   logic                       sys_clk;
   logic                       reset;
   cool_ctrl_pkg::remote_cmd_t cmd;
   cool_ctrl_pkg::temps_t      target;
   cool_ctrl_pkg::temps_t      temps;
   logic                       comp_enable;
   cool_ctrl_pkg::fan_tap_t    fan_tap;
   logic                       quiet_led;
   logic                       dew_active;
   logic                       pw = 1'b0;
   logic                       cl = 1'b1;
   logic                       qt = 1'b0;
   cool_ctrl_pkg::fan_sel_t    fs = cool_ctrl_pkg::FAN_AUTO;
   logic [7:0]                 ti = 8'h36;
   logic [7:0]                 tx = 8'h1e;
   int                         fail_count = 0;
   int                         n_tests = 0;
   cool_ctrl #(.SEC_CYCLES(SEC)) i_cool_ctrl (.sys_clk(sys_clk), .reset(reset), .cmd(cmd),
      .temps(temps), .comp_enable(comp_enable), .fan_tap(fan_tap), .quiet_led(quiet_led),
      .dew_active(dew_active));
   room_model i_room_model (.sys_clk(sys_clk), .target(target), .temps(temps));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic secs(input int n);
      repeat (n * SEC) @(negedge sys_clk);
   endtask
   // Setpoint fixed at 24C; intake and coil vary per scenario
   task automatic apply;
      @(posedge sys_clk);
      cmd <= '{pw, cl, qt, fs};
      target <= '{ti, 8'h30, tx};
      @(negedge sys_clk);
   endtask
   function automatic logic pick(input int s);
      return s ? dew_active : comp_enable;
   endfunction
   // Level must still be old two seconds early and new within two late
   task automatic flip(input int s, input logic v, input int n);
      secs(n - 2);
      chk(pick(s), !v);
      for (int i = 0; i < 4 * SEC && pick(s) !== v; i++) @(negedge sys_clk);
      chk(pick(s), v);
   endtask
   initial begin
      reset = 1'b1;
      cmd = '0;
      target = '{8'h36, 8'h30, 8'h1e};
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      @(negedge sys_clk);
      chk(comp_enable, 1'b0);
      pw = 1'b1;
      // Sweep manual taps, plain then quiet
      for (int k = 0; k < 6; k++) begin
         fs = cool_ctrl_pkg::fan_sel_t'(3 - k % 3);
         qt = 1'(k / 3);
         apply();
         @(negedge sys_clk);
         chk(fan_tap, 4'(k % 3 + 1 + (k / 3) * 4));
         chk(quiet_led, qt);
      end
      cl = 1'b0;
      apply();
      @(negedge sys_clk);
      chk(fan_tap, cool_ctrl_pkg::TAP_STOP);
      cl = 1'b1;
      qt = 1'b0;
      fs = cool_ctrl_pkg::FAN_AUTO;
      apply();
      flip(0, 1'b1, 175);
      chk(fan_tap, cool_ctrl_pkg::TAP_TOP);
      ti = 8'h2f;
      apply();
      flip(0, 1'b0, 2);
      chk(fan_tap, cool_ctrl_pkg::TAP_TOP);
      ti = 8'h36;
      apply();
      flip(0, 1'b1, 180);
      repeat (2) @(negedge sys_clk);
      chk(fan_tap, cool_ctrl_pkg::TAP_MIDDLE);
      ti = 8'h30;
      apply();
      flip(0, 1'b0, 2);
      ti = 8'h31;
      apply();
      flip(0, 1'b1, 420);
      tx = 8'h03;
      apply();
      flip(0, 1'b0, 240);
      chk(fan_tap, cool_ctrl_pkg::TAP_MIDDLE);
      tx = 8'h13;
      ti = 8'h36;
      apply();
      secs(200);
      chk(comp_enable, 1'b0);
      tx = 8'h14;
      apply();
      flip(0, 1'b1, 2);
      secs(300);
      chk(comp_enable, 1'b1);
      tx = 8'h32;
      apply();
      flip(0, 1'b0, 120);
      tx = 8'h1e;
      apply();
      flip(0, 1'b1, 180);
      fs = cool_ctrl_pkg::FAN_LOW;
      apply();
      @(negedge sys_clk);
      chk(fan_tap, cool_ctrl_pkg::TAP_BOTTOM);
      flip(1, 1'b1, 1799);
      repeat (2) @(negedge sys_clk);
      chk(fan_tap, cool_ctrl_pkg::TAP_BOOSTED);
      fs = cool_ctrl_pkg::FAN_MED;
      apply();
      chk(dew_active, 1'b0);
      fs = cool_ctrl_pkg::FAN_LOW;
      apply();
      secs(2);
      chk(dew_active, 1'b0);
      qt = 1'b1;
      apply();
      @(negedge sys_clk);
      chk(fan_tap, cool_ctrl_pkg::TAP_QUIET_BOTTOM);
      secs(3597);
      chk(fan_tap, cool_ctrl_pkg::TAP_QUIET_BOTTOM);
      secs(4);
      chk(fan_tap, cool_ctrl_pkg::TAP_QUIET_BOT_100);
      secs(1796);
      chk(fan_tap, cool_ctrl_pkg::TAP_QUIET_BOT_100);
      secs(4);
      chk(fan_tap, cool_ctrl_pkg::TAP_QUIET_BOT_180);
      secs(100);
      chk(fan_tap, cool_ctrl_pkg::TAP_QUIET_BOT_180);
      chk(quiet_led, 1'b1);
      report_and_stop();
   end
   // Whole sequence is about 36000 cycles
   initial begin
      repeat (50000) @(posedge sys_clk);
      fail_count++;
      report_and_stop();
   end
endmodule
bind cool_ctrl cool_ctrl_checker #(.SEC_CYCLES(SEC_CYCLES)) i_cool_ctrl_checker (
   .sys_clk(sys_clk), .reset(reset), .cmd(cmd), .temps(temps), .comp_enable(comp_enable),
   .fan_tap(fan_tap), .quiet_led(quiet_led), .dew_active(dew_active));
